// file: hdl/move_mult_consts.vh
/*
 * Constants for the move and multiply decoder: instruction form codes,
 * operand classes, cycle and byte figures.
 * Assumes the fetch path has already split the instruction into fields.
 */
`ifndef MOVE_MULT_CONSTS_VH
`define MOVE_MULT_CONSTS_VH

`define FORM_SHORT_TO_ADDR 4'h0
`define FORM_SHORT_STORE 4'h1
`define FORM_SHORT_LOAD 4'h2
`define FORM_SP_LOAD 4'h3
`define FORM_SP_STORE 4'h4
`define FORM_EA_LOAD 4'h5
`define FORM_NIBBLE_TO_ACC 4'h6
`define FORM_NIBBLE_FROM_ACC 4'h7
`define FORM_SMUL_IMM 4'h8
`define FORM_UMUL_IMM 4'h9
`define FORM_SMUL_GEN 4'ha
`define FORM_UMUL_GEN 4'hb

`define CLASS_DATA 3'h0
`define CLASS_ADDR 3'h1
`define CLASS_IND 3'h2
`define CLASS_DSP 3'h3
`define CLASS_SB16 3'h4
`define CLASS_ABS 3'h5
`define CLASS_NONE 3'h7

`define CODE_FIRST_ADDR 4'h4
`define CODE_SECOND_ADDR 4'h5
`define CODE_FIRST_IND 4'h6
`define CODE_FIRST_DSP8 4'h8
`define CODE_FIRST_DSP16 4'hc
`define CODE_SB16 4'he
`define CODE_ABS 4'hf

`define DIR_LL 2'h0
`define DIR_HL 2'h1
`define DIR_LH 2'h2
`define DIR_HH 2'h3

`define CYC_1 4'h1
`define CYC_2 4'h2
`define CYC_3 4'h3
`define CYC_4 4'h4
`define CYC_5 4'h5
`define CYC_6 4'h6
`define CYC_7 4'h7
`define CYC_8 4'h8

`define LEN_1 3'h1
`define LEN_2 3'h2
`define LEN_3 3'h3

`endif

// file: hdl/move_mult_decoder.v
/*
 * Cycle and length decoder for the move, effective address, nibble and
 * multiply forms of the core.
 * Assumes fields arrive split out and synchronous to clk_in, one request a
 * cycle at most; the answer follows one clock after the request.
 */
`timescale 1ns/1ns
`include "move_mult_consts.vh"

module move_mult_decoder
(
    input wire clk_in,
    input wire rst_b_in,
    input wire req_valid_in,
    input wire [3:0] form_in,
    input wire size_word_in,
    input wire [3:0] src_code_in,
    input wire [3:0] dst_code_in,
    input wire [1:0] dir_in,
    output reg done_out,
    output reg undefined_out,
    output reg [2:0] byte_count_out,
    output reg [3:0] cycle_count_out,
    output reg [2:0] src_class_out,
    output reg [2:0] dst_class_out,
    output reg word_out,
    output reg product_signed_out
);

    reg rst_sync_a;
    reg rst_sync_b;
    reg next_undefined;
    reg [2:0] next_bytes;
    reg [3:0] next_cycles;
    reg [2:0] next_src_class;
    reg [2:0] next_dst_class;
    reg next_word;
    reg next_signed;
    reg src_mem;
    reg dst_mem;
    reg same_half;

    // Extra bytes carried by a general operand code.
    function [2:0] disp_bytes;
        input [3:0] code;
        begin
            if (code >= `CODE_FIRST_DSP16)
                disp_bytes = 3'h2;
            else if (code >= `CODE_FIRST_DSP8)
                disp_bytes = 3'h1;
            else
                disp_bytes = 3'h0;
        end
    endfunction

    // Operand class of a general four-bit code.
    function [2:0] class_of;
        input [3:0] code;
        begin
            if (code == `CODE_ABS)
                class_of = `CLASS_ABS;
            else if (code == `CODE_SB16)
                class_of = `CLASS_SB16;
            else if (code >= `CODE_FIRST_DSP8)
                class_of = `CLASS_DSP;
            else if (code >= `CODE_FIRST_IND)
                class_of = `CLASS_IND;
            else if (code >= `CODE_FIRST_ADDR)
                class_of = `CLASS_ADDR;
            else
                class_of = `CLASS_DATA;
        end
    endfunction

    // Class of the two-bit short-form operand field.
    function [2:0] short_class;
        input [1:0] code;
        begin
            case (code)
                2'h0: short_class = `CLASS_DATA;
                2'h3: short_class = `CLASS_ABS;
                default: short_class = `CLASS_DSP;
            endcase
        end
    endfunction

    // Multiply target check.
    function mul_dst_ok;
        input [3:0] code;
        input word;
        begin
            case (code)
                4'h3: mul_dst_ok = 1'b0;
                4'h5: mul_dst_ok = 1'b0;
                4'h1: mul_dst_ok = word;
                4'h2: mul_dst_ok = ~word;
                default: mul_dst_ok = 1'b1;
            endcase
        end
    endfunction

    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_sync_a <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_sync_a <= 1'b1;
            rst_sync_b <= rst_sync_a;
        end
    end

    always @*
    begin
        src_mem = (src_code_in >= `CODE_FIRST_IND);
        dst_mem = (dst_code_in >= `CODE_FIRST_IND);
        same_half = (dir_in == `DIR_LL) || (dir_in == `DIR_HH);
        next_undefined = 1'b0;
        next_bytes = `LEN_2;
        next_cycles = `CYC_2;
        next_src_class = class_of(src_code_in);
        next_dst_class = class_of(dst_code_in);
        next_word = size_word_in;
        next_signed = 1'b0;
        case (form_in)
            `FORM_SHORT_TO_ADDR:
            begin
                next_word = 1'b0;
                next_src_class = short_class(src_code_in[1:0]);
                next_dst_class = `CLASS_ADDR;
                case (src_code_in[1:0])
                    2'h0:
                    begin
                        next_bytes = `LEN_1;
                        next_cycles = `CYC_2;
                    end
                    2'h3:
                    begin
                        next_bytes = `LEN_3;
                        next_cycles = `CYC_3;
                    end
                    default:
                    begin
                        next_bytes = `LEN_2;
                        next_cycles = `CYC_3;
                    end
                endcase
            end
            `FORM_SHORT_STORE:
            begin
                next_word = 1'b0;
                next_src_class = `CLASS_DATA;
                next_dst_class = short_class(dst_code_in[1:0]);
                next_cycles = `CYC_2;
                if (dst_code_in[1:0] == 2'h3)
                    next_bytes = `LEN_3;
                else
                    next_bytes = `LEN_2;
                if (dst_code_in[1:0] == 2'h0)
                    next_undefined = 1'b1;
            end
            `FORM_SHORT_LOAD:
            begin
                next_word = 1'b0;
                next_src_class = short_class(src_code_in[1:0]);
                next_dst_class = `CLASS_DATA;
                case (src_code_in[1:0])
                    2'h0:
                    begin
                        next_bytes = `LEN_1;
                        next_cycles = `CYC_2;
                    end
                    2'h3:
                    begin
                        next_bytes = `LEN_3;
                        next_cycles = `CYC_3;
                    end
                    default:
                    begin
                        next_bytes = `LEN_2;
                        next_cycles = `CYC_3;
                    end
                endcase
            end
            `FORM_SP_LOAD:
            begin
                next_src_class = `CLASS_DSP;
                next_bytes = `LEN_3 + disp_bytes(dst_code_in);
                next_cycles = dst_mem ? `CYC_3 : `CYC_2;
            end
            `FORM_SP_STORE:
            begin
                next_dst_class = `CLASS_DSP;
                next_bytes = `LEN_3 + disp_bytes(src_code_in);
                next_cycles = src_mem ? `CYC_4 : `CYC_3;
            end
            `FORM_EA_LOAD:
            begin
                next_word = 1'b1;
                next_dst_class = dst_code_in[2] ? `CLASS_ADDR : `CLASS_DATA;
                next_cycles = `CYC_2;
                if (src_code_in < `CODE_FIRST_DSP16)
                    next_bytes = `LEN_3;
                else
                    next_bytes = 3'h4;
                if ((src_code_in < `CODE_FIRST_DSP8) ||
                    (dst_code_in[3]) || (dst_code_in[2:1] == 2'h3))
                    next_undefined = 1'b1;
            end
            `FORM_NIBBLE_TO_ACC:
            begin
                next_word = 1'b0;
                next_dst_class = `CLASS_DATA;
                next_bytes = `LEN_2 + disp_bytes(src_code_in);
                if (same_half)
                    next_cycles = src_mem ? `CYC_5 : `CYC_3;
                else
                    next_cycles = src_mem ? `CYC_8 : `CYC_6;
                if ((src_code_in == `CODE_FIRST_ADDR) ||
                    (src_code_in == `CODE_SECOND_ADDR))
                    next_undefined = 1'b1;
            end
            `FORM_NIBBLE_FROM_ACC:
            begin
                next_word = 1'b0;
                next_src_class = `CLASS_DATA;
                next_bytes = `LEN_2 + disp_bytes(dst_code_in);
                if (same_half)
                    next_cycles = dst_mem ? `CYC_5 : `CYC_4;
                else
                    next_cycles = dst_mem ? `CYC_8 : `CYC_7;
                if ((dst_code_in == 4'h0) ||
                    (dst_code_in == `CODE_FIRST_ADDR) ||
                    (dst_code_in == `CODE_SECOND_ADDR))
                    next_undefined = 1'b1;
            end
            `FORM_SMUL_IMM, `FORM_UMUL_IMM:
            begin
                next_signed = ~form_in[0];
                next_src_class = `CLASS_NONE;
                next_bytes = `LEN_3 + disp_bytes(dst_code_in) +
                    {2'h0, size_word_in};
                if (!dst_mem)
                    next_cycles = size_word_in ? `CYC_5 : `CYC_4;
                else
                    next_cycles = size_word_in ? `CYC_7 : `CYC_5;
                if (!mul_dst_ok(dst_code_in, size_word_in))
                    next_undefined = 1'b1;
            end
            `FORM_SMUL_GEN, `FORM_UMUL_GEN:
            begin
                next_signed = ~form_in[0];
                next_bytes = `LEN_2 + disp_bytes(src_code_in) +
                    disp_bytes(dst_code_in);
                if (src_mem)
                    next_cycles = `CYC_6;
                else if (dst_mem)
                    next_cycles = `CYC_5;
                else if (src_code_in[2] && dst_code_in[2])
                    next_cycles = `CYC_5;
                else
                    next_cycles = `CYC_4;
                if (size_word_in)
                begin
                    if (dst_mem)
                        next_cycles = next_cycles + `CYC_2;
                    else if (!src_code_in[2] || src_mem)
                        next_cycles = next_cycles + `CYC_1;
                    else if (!dst_code_in[2])
                        next_cycles = next_cycles + `CYC_1;
                end
                if (!mul_dst_ok(dst_code_in, size_word_in))
                    next_undefined = 1'b1;
            end
            default:
            begin
                next_undefined = 1'b1;
                next_src_class = `CLASS_NONE;
                next_dst_class = `CLASS_NONE;
            end
        endcase
    end

    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            done_out <= 1'b0;
            undefined_out <= 1'b0;
            byte_count_out <= 3'h0;
            cycle_count_out <= 4'h0;
            src_class_out <= `CLASS_NONE;
            dst_class_out <= `CLASS_NONE;
            word_out <= 1'b0;
            product_signed_out <= 1'b0;
        end
        else if (!rst_sync_b)
        begin
            done_out <= 1'b0;
            undefined_out <= 1'b0;
        end
        else
        begin
            done_out <= req_valid_in;
            if (req_valid_in)
            begin
                undefined_out <= next_undefined;
                byte_count_out <= next_bytes;
                cycle_count_out <= next_cycles;
                src_class_out <= next_src_class;
                dst_class_out <= next_dst_class;
                word_out <= next_word;
                product_signed_out <= next_signed;
            end
        end
    end

endmodule // move_mult_decoder

// file: bench/fetch_feed.sv
/*
 * Program memory model: hands the decoder one split instruction a call.
 * Assumes the decoder samples its request on the rising edge of clk_in.
 */
`timescale 1ns/1ns
module fetch_feed
(
    input wire clk_in,
    output reg req_valid_out = 1'h0,
    output reg [3:0] form_out = 4'h0,
    output reg size_word_out = 1'h0,
    output reg [3:0] src_code_out = 4'h0,
    output reg [3:0] dst_code_out = 4'h0,
    output reg [1:0] dir_out = 2'h0
);
    // Released fields turn to their inverse so stale values cannot pass.
    task send(input [3:0] f, input s, input [3:0] a, input [3:0] b,
        input [1:0] d);
    begin
        @(posedge clk_in);
        req_valid_out <= 1'h1;
        {form_out, size_word_out, src_code_out, dst_code_out, dir_out} <=
            {f, s, a, b, d};
        @(posedge clk_in);
        req_valid_out <= 1'h0;
        {form_out, size_word_out, src_code_out, dst_code_out, dir_out} <=
            ~{f, s, a, b, d};
    end
    endtask
endmodule // fetch_feed

// file: bench/move_mult_properties.sv
/*
 * Port assertions for the move and multiply decoder.
 * Assumes only the decoder's ports are visible; bound after the module.
 */
`timescale 1ns/1ns
module move_mult_checker
(
    input wire clk_in,
    input wire rst_b_in,
    input wire req_valid_in,
    input wire [3:0] form_in,
    input wire size_word_in,
    input wire [3:0] src_code_in,
    input wire [3:0] dst_code_in,
    input wire [1:0] dir_in,
    input wire done_out,
    input wire undefined_out,
    input wire [2:0] byte_count_out,
    input wire [3:0] cycle_count_out,
    input wire [2:0] src_class_out,
    input wire [2:0] dst_class_out,
    input wire word_out,
    input wire product_signed_out
);
    reg [1:0] up;
    wire live;
    // Requests count only once the reset synchroniser has settled.
    always @(posedge clk_in or negedge rst_b_in)
        up <= !rst_b_in ? 2'h0 : up + {1'h0, up != 2'h3};
    assign live = req_valid_in && up == 2'h3;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    mul_size_a: assert property (
        live && form_in[3:2] == 2'h2 |=> done_out &&
        word_out == $past(size_word_in)) else $error("multiply size lost");
    held_output_a: assert property (
        !done_out |-> $stable(cycle_count_out) && $stable(undefined_out))
        else $error("answer changed without a request");
    short_addr_a: assert property (
        live && form_in == 4'h0 && src_code_in[1:0] == 2'h0 |=>
        cycle_count_out == 4'h2 && byte_count_out == 3'h1)
        else $error("short copy register source counts");
    short_load_a: assert property (
        live && form_in == 4'h2 && src_code_in[1:0] != 2'h0 |=>
        cycle_count_out == 4'h3) else $error("short load memory cycles");
    ea_load_a: assert property (
        live && form_in == 4'h5 && src_code_in[3] && dst_code_in < 4'h6
        |=> cycle_count_out == 4'h2 && !undefined_out) else $error("ea load");
    mul_excluded_a: assert property (
        live && form_in[3:2] == 2'h2 && (dst_code_in == 4'h3 ||
        dst_code_in == 4'h5) |=> undefined_out) else $error("excluded code");
    nibble_cross_a: assert property (
        live && form_in == 4'h6 && src_code_in[3:2] == 2'h0 && (dir_in == 2'h1
        || dir_in == 2'h2) |=> cycle_count_out == 4'h6) else $error("nibble");
    mul_mem_word_a: assert property (
        live && form_in[3:1] == 3'h5 && size_word_in && dst_code_in[3] &&
        src_code_in[3:2] == 2'h0 |=> cycle_count_out == 4'h7)
        else $error("word multiply to memory cycles");
    signed_flag_a: assert property (
        live && form_in[3:2] == 2'h2 |=> product_signed_out ==
        ($past(form_in) == 4'h8 || $past(form_in) == 4'ha))
        else $error("multiply signedness wrong");
    operand_class_a: assert property (
        live && form_in[3:1] == 3'h5 && src_code_in == 4'h6 &&
        dst_code_in == 4'he |=> src_class_out == 3'h2 &&
        dst_class_out == 3'h4) else $error("operand class wrong");
    ea_target_a: assert property (
        live && form_in == 4'h5 && dst_code_in == 4'h4 |=>
        dst_class_out == 3'h1) else $error("address load target class");
endmodule // move_mult_checker

bind move_mult_decoder move_mult_checker i_move_mult_checker (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
    .form_in(form_in), .size_word_in(size_word_in), .dir_in(dir_in),
    .src_code_in(src_code_in), .dst_code_in(dst_code_in),
    .done_out(done_out), .undefined_out(undefined_out), .word_out(word_out),
    .byte_count_out(byte_count_out), .cycle_count_out(cycle_count_out),
    .src_class_out(src_class_out), .dst_class_out(dst_class_out),
    .product_signed_out(product_signed_out));

// file: bench/test_cpu_move_multiply_decoder.sv
/*
 * Self-checking bench for the move and multiply decoder.
 * Assumes one 250 MHz clock and the fetch_feed program memory model.
 */
`timescale 1ns/1ns
module test_cpu_move_multiply_decoder;
    reg clk_in = 1'h0;
    reg rst_b_in = 1'h0;
    reg [3:0] fm;
    integer err_total = 0;
    integer compares = 0;
    wire req_valid_in, size_word_in, done_out, undefined_out, word_out;
    wire [3:0] form_in, src_code_in, dst_code_in, cycle_count_out;
    wire [2:0] byte_count_out;
    wire [1:0] dir_in;
    always #2 clk_in = ~clk_in;
    fetch_feed i_fetch_feed (.clk_in(clk_in), .req_valid_out(req_valid_in),
        .form_out(form_in), .size_word_out(size_word_in),
        .src_code_out(src_code_in), .dst_code_out(dst_code_in),
        .dir_out(dir_in));
    move_mult_decoder i_move_mult_decoder (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .req_valid_in(req_valid_in), .form_in(form_in),
        .size_word_in(size_word_in), .src_code_in(src_code_in),
        .dst_code_in(dst_code_in), .dir_in(dir_in), .done_out(done_out),
        .undefined_out(undefined_out), .byte_count_out(byte_count_out),
        .cycle_count_out(cycle_count_out), .src_class_out(),
        .dst_class_out(), .word_out(word_out), .product_signed_out());

    task close_out;
    begin
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    task fail(input [8*12-1:0] what);
    begin
        err_total = err_total + 1;
        $display("MISMATCH %0t %0s", $time, what);
    end
    endtask

    // Counts are only compared where the encoding is expected to be legal.
    task chk(input [3:0] c, input [2:0] n, input u);
    begin
        compares = compares + 1;
        if (undefined_out !== u || (!u && (cycle_count_out !== c ||
            byte_count_out !== n)))
            fail("counts");
    end
    endtask

    // Op packs form, source, destination, then size and direction.
    // Ex packs cycles and bytes; zero means an undefined encoding.
    task run(input [15:0] op, input [7:0] ex);
        integer k;
    begin
        i_fetch_feed.send(op[15:12], op[3], op[11:8], op[7:4], op[1:0]);
        #1;
        for (k = 0; done_out !== 1'h1 && k < 4; k = k + 1)
            @(posedge clk_in) #1;
        if (k == 4)
        begin
            fail("no answer");
            close_out;
        end
        else
            chk(ex[7:4], ex[2:0], ex == 8'h00);
    end
    endtask

    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        run(16'h0010, 8'h21);
        run(16'h0310, 8'h33);
        run(16'h1130, 8'h23);
        run(16'h1000, 8'h00);
        run(16'h2200, 8'h32);
        run(16'h3008, 8'h23);
        run(16'h30f0, 8'h35);
        run(16'h4100, 8'h33);
        run(16'h4c08, 8'h45);
        run(16'h5e40, 8'h24);
        run(16'h5700, 8'h00);
        run(16'h6000, 8'h32);
        run(16'h6102, 8'h62);
        run(16'h6f01, 8'h84);
        run(16'h7010, 8'h42);
        run(16'h7011, 8'h72);
        run(16'h70c2, 8'h84);
        run(16'h7000, 8'h00);
        $display("move forms done");
        for (fm = 4'h8; fm < 4'ha; fm = fm + 4'h1)
        begin
            run({fm, 12'h000}, 8'h43);
            run({fm, 12'h018}, 8'h54);
            run({fm, 12'h0f8}, 8'h76);
            run({fm, 12'h020}, 8'h43);
            run({fm, 12'h028}, 8'h00);
            run({fm, 12'h058}, 8'h00);
        end
        for (fm = 4'ha; fm < 4'hc; fm = fm + 4'h1)
        begin
            run({fm, 12'h080}, 8'h53);
            run({fm, 12'h440}, 8'h52);
            run({fm, 12'h6e0}, 8'h64);
            run({fm, 12'h408}, 8'h52);
            run({fm, 12'h148}, 8'h52);
            run({fm, 12'h088}, 8'h73);
            run({fm, 12'h888}, 8'h84);
        end
        run(16'hc000, 8'h00);
        $display("multiply forms done");
        close_out;
    end
endmodule // test_cpu_move_multiply_decoder
